// ### verilog/bsc_top.sv
// boundary-scan cells for clock options, analog comparator and converter controls
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_cfg.svh"

module bsc_top
    import bsc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // test access side, inputs all from the tck domain, tdo from a pclk flop
    input  wire logic              tck,
    input  wire logic              tdi,
    input  wire logic              capture_dr,
    input  wire logic              shift_dr,
    input  wire logic              update_dr,
    input  wire logic              external_test_instruction,
    output logic                   tdo,
    // observed lines from oscillators and analog blocks
    input  wire logic              ext_clock_line,
    input  wire logic              crystal_osc_clock,
    input  wire logic              ext_rc_clock,
    input  wire logic              low_freq_crystal_clock,
    input  wire logic              timer_osc_clock,
    input  wire logic              comparator_result,
    input  wire logic              converter_compare_out,
    // controls to oscillators
    output logic                   ext_clock_input_enable,
    output logic                   crystal_osc_enable,
    output logic                   ext_rc_osc_enable,
    output logic                   low_freq_crystal_enable,
    output logic                   timer_osc_enable,
    // controls to the comparator
    output logic                   comparator_off,
    output logic                   comparator_mux_select,
    output logic                   comparator_bandgap_enable,
    // controls to the converter
    output logic                   gain_stage_clock,
    output logic                   gain_path_enable,
    output logic                   converter_bandgap_select,
    output logic                   converter_power_on,
    output logic                   gain_stage_power_on,
    output logic [3:0]             dac_high_bits
);

    // ------------------------------------------------------------------------
    // synchronisers for the tck domain and for observed lines
    // ------------------------------------------------------------------------
    wire  [`BSC_NTAP-1:0]  tap_raw;
    wire  [`BSC_NOBS-1:0]  obs_raw;
    wire  [`BSC_NSYNC-1:0] sync_raw;
    wire  [`BSC_NSYNC-1:0] sync_q;
    wire  [`BSC_NTAP-1:0]  tap_s;
    wire  [`BSC_NOBS-1:0]  obs_s;
    logic                  tck_d_r;

    assign tap_raw[`BSC_T_TCK] = tck;
    assign tap_raw[`BSC_T_TDI] = tdi;
    assign tap_raw[`BSC_T_CAP] = capture_dr;
    assign tap_raw[`BSC_T_SHF] = shift_dr;
    assign tap_raw[`BSC_T_UPD] = update_dr;
    assign tap_raw[`BSC_T_EXT] = external_test_instruction;

    assign obs_raw[`BSC_O_EXT]  = ext_clock_line;
    assign obs_raw[`BSC_O_XOSC] = crystal_osc_clock;
    assign obs_raw[`BSC_O_RC]   = ext_rc_clock;
    assign obs_raw[`BSC_O_LFX]  = low_freq_crystal_clock;
    assign obs_raw[`BSC_O_TOSC] = timer_osc_clock;
    assign obs_raw[`BSC_O_CMP]  = comparator_result;
    assign obs_raw[`BSC_O_CNV]  = converter_compare_out;

    assign sync_raw = {obs_raw, tap_raw};

    // two flops per asynchronous input; only the second one is read
    genvar si;
    generate
        for (si = 0; si < `BSC_NSYNC; si = si + 1) begin : g_sync
            logic s1_r;
            logic s2_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_r <= `BSC_SYNC_RST;
                    s2_r <= `BSC_SYNC_RST;
                end else begin
                    s1_r <= sync_raw[si];
                    s2_r <= s1_r;
                end
            end
            assign sync_q[si] = s2_r;
        end
    endgenerate

    assign tap_s = sync_q[`BSC_NTAP-1:0];
    assign obs_s = sync_q[`BSC_NSYNC-1:`BSC_NTAP];

    // delayed copy matches the idle-low test clock, so reset gives no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_d_r <= `BSC_SYNC_RST;
        end else begin
            tck_d_r <= tap_s[`BSC_T_TCK];
        end
    end

    wire tck_s     = tap_s[`BSC_T_TCK];
    wire tdi_s     = tap_s[`BSC_T_TDI];
    wire cap_s     = tap_s[`BSC_T_CAP];
    wire shf_s     = tap_s[`BSC_T_SHF];
    wire upd_s     = tap_s[`BSC_T_UPD];
    wire ext_s     = tap_s[`BSC_T_EXT];
    wire tck_rise  = tck_s & ~tck_d_r;
    wire tck_fall  = ~tck_s & tck_d_r;

    // ------------------------------------------------------------------------
    // observed values at the boundary
    // ------------------------------------------------------------------------
    bsc_ctrl_t             drive_r;
    wire  [`BSC_NOBS-1:0]  obs_eff;
    wire  [`BSC_NCLK-1:0]  clk_idle = `BSC_CLK_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < `BSC_NCLK; gi = gi + 1) begin : g_clk_obs
            // a disabled option shows its idle level
            assign obs_eff[gi] = drive_r[gi] ? obs_s[gi] : clk_idle[gi];
        end
    endgenerate

    assign obs_eff[`BSC_O_CMP] = ~drive_r[`BSC_C_CMP_OFF] & obs_s[`BSC_O_CMP];
    assign obs_eff[`BSC_O_CNV] = drive_r[`BSC_C_CNV_PWR] & obs_s[`BSC_O_CNV];

    // ------------------------------------------------------------------------
    // scan chain: controls in bits 0..16, observes in bits 17..23
    // ------------------------------------------------------------------------
    bsc_chain_t shift_r;
    bsc_chain_t shift_nxt;
    bsc_ctrl_t  upd_r;
    logic       tdo_r;

    wire cap_take  = tck_rise & cap_s;
    wire shf_take  = tck_rise & shf_s;
    wire upd_take  = tck_fall & upd_s;

    // no cell for the internal rc oscillator or the internal capacitor fuse
    always_comb begin
        shift_nxt = shift_r;
        if (cap_take) begin
            shift_nxt = {obs_eff, drive_r};
        end else if (shf_take) begin
            shift_nxt = {tdi_s, shift_r[`BSC_NCHAIN-1:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= `BSC_CHAIN_RST;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_r <= `BSC_CTRL_RST;
        end else if (upd_take) begin
            upd_r <= shift_r[`BSC_NCTRL-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_r <= shift_r[0];
        end
    end

    // ------------------------------------------------------------------------
    // apb registers: functional values, driven values, observed values
    // ------------------------------------------------------------------------
    bsc_ctrl_t   func_r;
    bsc_ctrl_t   drive_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic        err_nxt;

    function automatic logic addr_is(input logic [`BSC_AW-1:0] a, input logic [`BSC_AW-1:0] off);
        return a == off;
    endfunction : addr_is

    wire setup_ph  = psel & ~penable;
    wire wr_take   = psel & penable & pready_r & pwrite;
    wire sel_func  = addr_is(paddr, `BSC_OFF_FUNC);
    wire sel_drive = addr_is(paddr, `BSC_OFF_DRIVE);
    wire sel_obs   = addr_is(paddr, `BSC_OFF_OBS);

    always_comb begin
        rd_nxt  = `BSC_ZERO32;
        err_nxt = 1'b0;
        if (sel_func) begin
            rd_nxt[`BSC_NCTRL-1:0] = func_r;
        end else if (sel_drive) begin
            err_nxt = pwrite;
            rd_nxt[`BSC_NCTRL-1:0] = drive_r;
        end else if (sel_obs) begin
            err_nxt = pwrite;
            rd_nxt[`BSC_NOBS-1:0]         = obs_eff;
            rd_nxt[`BSC_OBS_EXT_BIT]      = ext_s;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // latched update values take over as soon as external test is loaded
    assign drive_nxt = ext_s ? upd_r : func_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= `BSC_CTRL_RST;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    // read data and error are fixed at setup and stand through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= `BSC_ZERO32;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? `BSC_ZERO32 : rd_nxt;
            pslverr_r <= err_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_r <= `BSC_CTRL_RST;
        end else if (wr_take && sel_func) begin
            func_r <= pwdata[`BSC_NCTRL-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------------
    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = pslverr_r;
    assign tdo                       = tdo_r;
    assign ext_clock_input_enable    = drive_r[`BSC_C_EXT_EN];
    assign crystal_osc_enable        = drive_r[`BSC_C_XOSC_EN];
    assign ext_rc_osc_enable         = drive_r[`BSC_C_RC_EN];
    assign low_freq_crystal_enable   = drive_r[`BSC_C_LFX_EN];
    assign timer_osc_enable          = drive_r[`BSC_C_TOSC_EN];
    assign comparator_off            = drive_r[`BSC_C_CMP_OFF];
    assign comparator_mux_select     = drive_r[`BSC_C_CMP_MUX];
    assign comparator_bandgap_enable = drive_r[`BSC_C_CMP_BG];
    assign gain_stage_clock          = drive_r[`BSC_C_GAIN_CLK];
    assign gain_path_enable          = drive_r[`BSC_C_GAIN_PATH];
    assign converter_bandgap_select  = drive_r[`BSC_C_CNV_BG];
    assign converter_power_on        = drive_r[`BSC_C_CNV_PWR];
    assign gain_stage_power_on       = drive_r[`BSC_C_GAIN_PWR];
    assign dac_high_bits             = drive_r[`BSC_NCTRL-1:`BSC_C_DAC_LO];

endmodule : bsc_top
`default_nettype wire

// ### include/bsc_cfg.svh
// constants for the clock and analog boundary-scan segment
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// ----------------------------------------------------------------------------
// chain geometry
// ----------------------------------------------------------------------------
`define BSC_NCTRL        17
`define BSC_NOBS         7
`define BSC_NCHAIN       24
`define BSC_NCLK         5
`define BSC_NDAC         4
`define BSC_NTAP         6
`define BSC_NSYNC        13

// ----------------------------------------------------------------------------
// tap-side input positions in the synchroniser vector
// ----------------------------------------------------------------------------
`define BSC_T_TCK        0
`define BSC_T_TDI        1
`define BSC_T_CAP        2
`define BSC_T_SHF        3
`define BSC_T_UPD        4
`define BSC_T_EXT        5

// ----------------------------------------------------------------------------
// control vector positions
// ----------------------------------------------------------------------------
`define BSC_C_EXT_EN     0
`define BSC_C_XOSC_EN    1
`define BSC_C_RC_EN      2
`define BSC_C_LFX_EN     3
`define BSC_C_TOSC_EN    4
`define BSC_C_CMP_OFF    5
`define BSC_C_CMP_MUX    6
`define BSC_C_CMP_BG     7
`define BSC_C_GAIN_CLK   8
`define BSC_C_GAIN_PATH  9
`define BSC_C_CNV_BG     10
`define BSC_C_CNV_PWR    11
`define BSC_C_GAIN_PWR   12
`define BSC_C_DAC_LO     13

// ----------------------------------------------------------------------------
// observe vector positions
// ----------------------------------------------------------------------------
`define BSC_O_EXT        0
`define BSC_O_XOSC       1
`define BSC_O_RC         2
`define BSC_O_LFX        3
`define BSC_O_TOSC       4
`define BSC_O_CMP        5
`define BSC_O_CNV        6

// ----------------------------------------------------------------------------
// reset and idle values
// ----------------------------------------------------------------------------
`define BSC_CTRL_RST     17'h10020
`define BSC_OBS_RST      7'h00
`define BSC_CHAIN_RST    24'h000000
`define BSC_CLK_IDLE     5'h04

// ----------------------------------------------------------------------------
// apb map
// ----------------------------------------------------------------------------
`define BSC_AW           12
`define BSC_OFF_FUNC     12'h000
`define BSC_OFF_DRIVE    12'h004
`define BSC_OFF_OBS      12'h008
`define BSC_OBS_EXT_BIT  8
`define BSC_ZERO32       32'h00000000
`define BSC_SYNC_RST     1'h0

`endif

// ### include/bsc_pkg.sv
// types for the clock and analog boundary-scan segment
`include "bsc_cfg.svh"

package bsc_pkg;
    typedef logic [`BSC_NCTRL-1:0]  bsc_ctrl_t;
    typedef logic [`BSC_NOBS-1:0]   bsc_obs_t;
    typedef logic [`BSC_NCHAIN-1:0] bsc_chain_t;
endpackage : bsc_pkg

// ### testbench/bsc_monitor.sv
// assertions on the clock and analog scan segment
`timescale 1ns/100ps
`default_nettype none
module bsc_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // scan side
    input wire logic        tck,
    input wire logic        update_dr,
    input wire logic        external_test_instruction,
    input wire logic        tdo,
    // driven controls
    input wire logic        comparator_off,
    input wire logic        converter_power_on,
    input wire logic [3:0]  dac_high_bits
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready too long");
    a_unmapped_refused: assert property (psel && !penable && paddr > 12'h008 |=> pslverr)
        else $error("unmapped access accepted");
    a_idle_after_reset: assert property (
        $rose(presetn) |-> comparator_off && dac_high_bits == 4'h8 && !converter_power_on)
        else $error("controls not idle after reset");
    a_hold_functional: assert property (
        (!external_test_instruction && !psel) [*8] |-> $stable(comparator_off) && $stable(dac_high_bits))
        else $error("controls moved without a write");
    a_hold_ext_test: assert property (
        (external_test_instruction && !update_dr) [*8] |-> $stable(comparator_off) && $stable(dac_high_bits))
        else $error("controls moved without an update");
    a_write_applies: assert property (
        psel && penable && pready && pwrite && paddr == 12'h000 && !external_test_instruction
        |-> ##2 dac_high_bits == $past(pwdata[16:13], 2) && comparator_off == $past(pwdata[5], 2))
        else $error("write not applied");
    a_tdo_on_fall: assert property (!$stable(tdo) |-> !tck)
        else $error("tdo moved while tck high");
endmodule : bsc_monitor
bind bsc_top bsc_monitor mon_u (.*);
`default_nettype wire

// ### testbench/bsc_jtag_model.sv
// test controller model driving the scan segment
`timescale 1ns/100ps
`default_nettype none
module bsc_jtag_model (
    // to the scan segment
    output logic     tck,
    output logic     tdi,
    output logic     capture_dr,
    output logic     shift_dr,
    output logic     update_dr,
    output logic     external_test_instruction,
    // from the scan segment
    input wire logic tdo
);
    initial {tck, tdi, capture_dr, shift_dr, update_dr, external_test_instruction} = 6'h00;
    // one 64 ns period, tdo taken just before the rising edge, tck idles low
    task automatic tick(output logic s);
        #23 s = tdo;
        #1 tck = 1'b1;
        #32 tck = 1'b0;
        #8;
    endtask : tick
    task automatic scan(input logic [23:0] din, output logic [23:0] dout);
        logic s;
        // step off the pclk edge so no input changes where it is sampled
        #1;
        capture_dr = 1'b1;
        tick(s);
        capture_dr = 1'b0;
        shift_dr = 1'b1;
        for (int i = 0; i < 24; i++) begin
            tdi = din[i];
            tick(dout[i]);
        end
        tdi = ~tdi;
        shift_dr = 1'b0;
        update_dr = 1'b1;
        tick(s);
        update_dr = 1'b0;
    endtask : scan
    task automatic set_ext(input logic v);
        #1 external_test_instruction = v;
        #64;
    endtask : set_ext
endmodule : bsc_jtag_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the clock and analog scan segment
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bsc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, tck, tdi, capture_dr, shift_dr, update_dr, external_test_instruction, tdo;
    logic ext_clock_line, crystal_osc_clock, ext_rc_clock, low_freq_crystal_clock, timer_osc_clock;
    logic comparator_result, converter_compare_out, ext_clock_input_enable, crystal_osc_enable;
    logic ext_rc_osc_enable, low_freq_crystal_enable, timer_osc_enable, comparator_off, comparator_mux_select;
    logic comparator_bandgap_enable, gain_stage_clock, gain_path_enable, converter_bandgap_select;
    logic converter_power_on, gain_stage_power_on;
    logic [3:0] dac_high_bits;
    logic [6:0] obs = 7'h00;
    logic [33:0] expq[$];
    int bad_count = 0, num_checks = 0, seed = 32'h591ebec3;
    bsc_ctrl_t outs, v, w;
    bsc_chain_t din, dout;
    assign {converter_compare_out, comparator_result, timer_osc_clock, low_freq_crystal_clock, ext_rc_clock,
            crystal_osc_clock, ext_clock_line} = obs;
    assign outs = {dac_high_bits, gain_stage_power_on, converter_power_on, converter_bandgap_select,
                   gain_path_enable, gain_stage_clock, comparator_bandgap_enable, comparator_mux_select,
                   comparator_off, timer_osc_enable, low_freq_crystal_enable, ext_rc_osc_enable,
                   crystal_osc_enable, ext_clock_input_enable};
    always #2 pclk = ~pclk;
    bsc_top dut_u (.*);
    bsc_jtag_model jtag_u (.*);
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0 && expq.size() == 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // e: [33] compare data, [32] expected error, [31:0] expected data
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        int n;
        expq.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        if (!pready) begin
            bad_count++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [6:0] masked(bsc_ctrl_t c, logic [6:0] o);
        return {o[6] & c[11], o[5] & ~c[5], o[4:3] & c[4:3], o[2] | ~c[2], o[1:0] & c[1:0]};
    endfunction : masked
    always @(posedge pclk) begin
        if (pready) begin
            if (expq.size() == 0) check("stray pready", 32'h1, 32'h0);
            else begin
                check("pslverr", pslverr, expq[0][32]);
                if (expq[0][33]) check("prdata", prdata, expq[0][31:0]);
                void'(expq.pop_front());
            end
        end
    end
    initial begin
        #100000 bad_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check("idle controls", outs, 17'h10020);
        apb(1'b0, 12'h000, 32'h0, {2'b10, 32'h00010020});
        apb(1'b1, 12'h004, 32'h0000FFFF, {2'b01, 32'h0});
        apb(1'b0, 12'h00C, 32'h0, {2'b11, 32'h0});
        for (int k = 0; k < 5; k++) begin
            v = 17'($random(seed));
            v[4:0] = 5'h01 << k;
            apb(1'b1, 12'h000, {15'h0, v}, 34'h0);
            repeat (2) @(posedge pclk);
            check("driven controls", outs, v);
            obs <= 7'($random(seed));
            repeat (6) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0, {2'b10, 25'h0, masked(v, obs)});
        end
        din = 24'($random(seed));
        din[4:0] = 5'h01;
        jtag_u.scan(din, dout);
        check("captured chain", dout, {masked(v, obs), v});
        repeat (4) @(posedge pclk);
        check("preload only", outs, v);
        jtag_u.set_ext(1'b1);
        @(posedge pclk);
        check("external drive", outs, din[16:0]);
        apb(1'b0, 12'h004, 32'h0, {2'b10, 15'h0, din[16:0]});
        w = din[16:0];
        din = 24'($random(seed));
        din[4:0] = 5'h08;
        jtag_u.scan(din, dout);
        check("captured drive", dout, {masked(w, obs), w});
        repeat (4) @(posedge pclk);
        check("updated drive", outs, din[16:0]);
        apb(1'b1, 12'h000, {15'h0, v ^ 17'h000E0}, 34'h0);
        check("held in test", outs, din[16:0]);
        jtag_u.set_ext(1'b0);
        @(posedge pclk);
        check("functional again", outs, v ^ 17'h000E0);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
